// *** meas_seq_map.vh ***
`ifndef MEAS_SEQ_MAP_VH
`define MEAS_SEQ_MAP_VH

// ********************************************************
// Register byte offsets
// ********************************************************
`define REG_CMD 8'h00
`define REG_CTRL 8'h04
`define REG_ARM_COUNT 8'h08
`define REG_TRIG_COUNT 8'h0C
`define REG_TRIG_DELAY 8'h10
`define REG_SETUP 8'h14
`define REG_STATUS 8'h18
`define REG_OUT_DATA 8'h1C
`define REG_CONF_RESP 8'h20

// ********************************************************
// Command register fields and opcodes
// ********************************************************
`define CMD_OP_LSB 0
`define CMD_FUNC_LSB 4
`define OP_NONE 4'h0
`define OP_CONF 4'h1
`define OP_CONF_Q 4'h2
`define OP_FETCH 4'h3
`define OP_READ 4'h4
`define OP_MEAS 4'h5
`define OP_INIT 4'h6
`define OP_ABORT 4'h7
`define OP_RESET 4'h8

// ********************************************************
// Measurement functions
// ********************************************************
`define FUNC_NONE 3'h0
`define FUNC_VOLT 3'h1
`define FUNC_CURR 3'h2
`define FUNC_RES 3'h3
`define FUNC_CHARGE 3'h4

// ********************************************************
// Control, setup and status fields
// ********************************************************
`define CTRL_TALK_BIT 0
`define CTRL_ELEM_LSB 1
`define SETUP_MATH_BIT 0
`define SETUP_AZERO_BIT 1
`define SETUP_BUF_BIT 2
`define SETUP_ARM_SRC_LSB 3
`define SETUP_TRIG_SRC_LSB 5
`define ST_IDLE_BIT 0
`define ST_PEND_BIT 1
`define ST_ERR_BIT 2
`define ST_AVAIL_BIT 3
`define ST_RESP_BIT 4
`define ST_FUNC_LSB 8

// ********************************************************
// Reset values
// ********************************************************
`define SRC_IMMEDIATE 2'h0
`define RST_COUNT 16'h0001
`define RST_DELAY 32'h00000000
`define RST_ELEM 3'h7
`define RST_FUNC 3'h1
`define RST_SETUP 7'h02

`endif

// *** reading_store.v ***
`timescale 1ns/1ps
// ********************************************************
// Reading-set memory, registered read data
// ********************************************************
module reading_store #(
    parameter WIDTH = 96,
    parameter AW = 6
) (
    input wire sys_clk,
    input wire ce,
    input wire wr_en,
    input wire [AW-1:0] wr_addr,
    input wire [WIDTH-1:0] wr_data,
    input wire [AW-1:0] rd_addr,
    output reg [WIDTH-1:0] rd_data
);
    reg [WIDTH-1:0] mem [0:(1<<AW)-1];

    // Write port and registered read port
    always @(posedge sys_clk) begin
        if (ce) begin
            if (wr_en)
                mem[wr_addr] <= wr_data;
            rd_data <= mem[rd_addr];
        end
    end
endmodule // reading_store

// *** axil_slave.v ***
`timescale 1ns/1ps
// ********************************************************
// AXI4-Lite slave front end: strobes toward register file
// ********************************************************
module axil_slave (
    input wire sys_clk,
    input wire arst_n,
    input wire ce,
    input wire [7:0] s_awaddr,
    input wire s_awvalid,
    output wire s_awready,
    input wire [31:0] s_wdata,
    input wire [3:0] s_wstrb,
    input wire s_wvalid,
    output wire s_wready,
    output reg [1:0] s_bresp,
    output reg s_bvalid,
    input wire s_bready,
    input wire [7:0] s_araddr,
    input wire s_arvalid,
    output wire s_arready,
    output wire [31:0] s_rdata,
    output wire [1:0] s_rresp,
    output reg s_rvalid,
    input wire s_rready,
    output wire wr_stb,
    output reg [7:0] wr_addr,
    output reg [31:0] wr_data,
    output reg [3:0] wr_strb,
    input wire wr_err,
    output reg rd_stb,
    output reg [7:0] rd_addr,
    input wire [31:0] rd_data,
    input wire rd_err
);
    reg aw_held_r;
    reg w_held_r;
    reg rd_busy_r;

    assign s_awready = ~aw_held_r & ~s_bvalid;
    assign s_wready = ~w_held_r & ~s_bvalid;
    assign s_arready = ~rd_busy_r;
    assign wr_stb = ce & aw_held_r & w_held_r & ~s_bvalid;
    assign s_rdata = rd_data;
    assign s_rresp = rd_err ? 2'h2 : 2'h0;

    // Write channel: address and data in either order
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_bvalid <= 1'b0;
            s_bresp <= 2'h0;
            wr_addr <= 8'h00;
            wr_data <= 32'h00000000;
            wr_strb <= 4'h0;
        end else if (ce) begin
            if (s_awvalid && s_awready) begin
                aw_held_r <= 1'b1;
                wr_addr <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_held_r <= 1'b1;
                wr_data <= s_wdata;
                wr_strb <= s_wstrb;
            end
            if (wr_stb) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp <= wr_err ? 2'h2 : 2'h0;
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // Read channel: strobe, then data one cycle later
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_busy_r <= 1'b0;
            rd_stb <= 1'b0;
            s_rvalid <= 1'b0;
            rd_addr <= 8'h00;
        end else if (ce) begin
            rd_stb <= s_arvalid & s_arready;
            if (s_arvalid && s_arready) begin
                rd_busy_r <= 1'b1;
                rd_addr <= s_araddr;
            end
            if (rd_stb)
                s_rvalid <= 1'b1;
            else if (s_rvalid && s_rready) begin
                s_rvalid <= 1'b0;
                rd_busy_r <= 1'b0;
            end
        end
    end
endmodule // axil_slave

// *** meas_seq.v ***
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "meas_seq_map.vh"
module meas_seq #(
    parameter AW = 6
) (
    input wire sys_clk,
    input wire arst_n,
    input wire ce,
    input wire [7:0] s_awaddr,
    input wire s_awvalid,
    output wire s_awready,
    input wire [31:0] s_wdata,
    input wire [3:0] s_wstrb,
    input wire s_wvalid,
    output wire s_wready,
    output wire [1:0] s_bresp,
    output wire s_bvalid,
    input wire s_bready,
    input wire [7:0] s_araddr,
    input wire s_arvalid,
    output wire s_arready,
    output wire [31:0] s_rdata,
    output wire [1:0] s_rresp,
    output wire s_rvalid,
    input wire s_rready,
    input wire rdg_valid,
    input wire [31:0] rdg_value,
    input wire [31:0] rdg_time,
    input wire [31:0] rdg_status,
    output reg meas_init,
    output reg meas_abort,
    output reg func_defaults,
    output reg store_abort,
    output reg [2:0] func_sel_r,
    output reg [15:0] arm_count_r,
    output reg [15:0] trig_count_r,
    output reg [31:0] trig_delay_r,
    output reg [6:0] setup_r
);
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN = 1'b1;

    wire wr_stb;
    wire [7:0] wr_addr;
    wire [31:0] wr_data;
    wire [3:0] wr_strb;
    wire rd_stb;
    wire [7:0] rd_addr;
    wire [95:0] mem_rd;
    reg wr_err;
    reg [31:0] rd_data_r;
    reg rd_err_r;
    reg state_r;
    reg talk_r;
    reg [2:0] elem_r;
    reg pend_r;
    reg [3:0] pend_op_r;
    reg [2:0] pend_func_r;
    reg fetch_after_r;
    reg cmd_err_r;
    reg resp_r;
    reg [2:0] conf_resp_r;
    reg [31:0] need_r;
    reg [31:0] got_r;
    reg [AW-1:0] grp_len_r;
    reg [AW-1:0] out_set_r;
    reg [AW-1:0] out_len_r;
    reg [1:0] out_elem_r;
    reg [31:0] out_word;

    // ********************************************************
    // Helper functions
    // ********************************************************
    // Byte-lane merge for partial writes
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (strb[i])
                    merge[i*8 +: 8] = nw[i*8 +: 8];
        end
    endfunction

    // First selected element at or after position, 3 if none
    function [1:0] next_elem;
        input [2:0] sel;
        input [1:0] from;
        begin
            if (from == 2'h0 && sel[0])
                next_elem = 2'h0;
            else if (from <= 2'h1 && sel[1])
                next_elem = 2'h1;
            else if (from <= 2'h2 && sel[2])
                next_elem = 2'h2;
            else
                next_elem = 2'h3;
        end
    endfunction

    // Function code check: voltage, current, resistance, charge
    function func_ok;
        input [2:0] f;
        input allow_none;
        begin
            func_ok = (f >= `FUNC_VOLT && f <= `FUNC_CHARGE) ||
                      (allow_none && f == `FUNC_NONE);
        end
    endfunction

    // ********************************************************
    // Bus front end and reading memory
    // ********************************************************
    axil_slave u_bus (
        .sys_clk(sys_clk), .arst_n(arst_n), .ce(ce),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
        .s_awready(s_awready), .s_wdata(s_wdata),
        .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
        .s_wready(s_wready), .s_bresp(s_bresp),
        .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata),
        .s_rresp(s_rresp), .s_rvalid(s_rvalid),
        .s_rready(s_rready), .wr_stb(wr_stb), .wr_addr(wr_addr),
        .wr_data(wr_data), .wr_strb(wr_strb), .wr_err(wr_err),
        .rd_stb(rd_stb), .rd_addr(rd_addr), .rd_data(rd_data_r),
        .rd_err(rd_err_r)
    );

    reading_store #(.WIDTH(96), .AW(AW)) u_store (
        .sys_clk(sys_clk), .ce(ce),
        .wr_en(state_r == ST_RUN && rdg_valid &&
               got_r < (32'h1 << AW)),
        .wr_addr(got_r[AW-1:0]),
        .wr_data({rdg_status, rdg_time, rdg_value}),
        .rd_addr(out_set_r), .rd_data(mem_rd)
    );

    // Write decode; unmapped or read-only gives error
    always @* begin
        case (wr_addr)
            `REG_CMD, `REG_CTRL, `REG_ARM_COUNT, `REG_TRIG_COUNT,
            `REG_TRIG_DELAY, `REG_SETUP, `REG_STATUS: wr_err = 1'b0;
            default: wr_err = 1'b1;
        endcase
    end

    // Element word of the current set
    always @* begin
        case (out_elem_r)
            2'h0: out_word = mem_rd[31:0];
            2'h1: out_word = mem_rd[63:32];
            2'h2: out_word = mem_rd[95:64];
            default: out_word = 32'h00000000;
        endcase
    end

    // ********************************************************
    // Sequencer, register file and output queue
    // ********************************************************
    wire cmd_wr = wr_stb && wr_addr == `REG_CMD && wr_strb[0];
    wire [3:0] cmd_op = wr_data[`CMD_OP_LSB +: 4];
    wire [2:0] cmd_func = wr_data[`CMD_FUNC_LSB +: 3];
    wire out_avail = out_len_r != {AW{1'b0}} && out_elem_r != 2'h3;
    wire pop = rd_stb && rd_addr == `REG_OUT_DATA && talk_r &&
               out_avail;
    wire run_done = state_r == ST_RUN && need_r != 32'h0 &&
                    (got_r + (rdg_valid ? 32'h1 : 32'h0)) >= need_r;
    wire idle_now = state_r == ST_IDLE;
    wire bad_func = cmd_wr && (cmd_op == `OP_CONF || cmd_op == `OP_MEAS)
                    && !func_ok(cmd_func, cmd_op == `OP_MEAS);
    // Abort and reset act at once
    wire urgent = cmd_op == `OP_ABORT || cmd_op == `OP_RESET;
    wire take_new = cmd_wr && !bad_func && !urgent && idle_now &&
                    !pend_r;
    wire take_pend = pend_r && idle_now;
    wire [3:0] ex_op = take_pend ? pend_op_r :
                       (take_new ? cmd_op : `OP_NONE);
    wire [2:0] ex_func = take_pend ? pend_func_r : cmd_func;
    wire infinite = arm_count_r == 16'h0 || trig_count_r == 16'h0;
    wire [15:0] cnt_a = (ex_op == `OP_MEAS) ? `RST_COUNT : arm_count_r;
    wire [15:0] cnt_t = (ex_op == `OP_MEAS) ? `RST_COUNT : trig_count_r;
    wire [31:0] arm_mrg = merge({16'h0, arm_count_r}, wr_data, wr_strb);
    wire [31:0] trig_mrg = merge({16'h0, trig_count_r}, wr_data, wr_strb);

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ST_IDLE;
            talk_r <= 1'b0;
            elem_r <= `RST_ELEM;
            func_sel_r <= `RST_FUNC;
            arm_count_r <= `RST_COUNT;
            trig_count_r <= `RST_COUNT;
            trig_delay_r <= `RST_DELAY;
            setup_r <= `RST_SETUP;
            pend_r <= 1'b0;
            pend_op_r <= `OP_NONE;
            pend_func_r <= `FUNC_NONE;
            fetch_after_r <= 1'b0;
            cmd_err_r <= 1'b0;
            resp_r <= 1'b0;
            conf_resp_r <= `FUNC_NONE;
            need_r <= 32'h0;
            got_r <= 32'h0;
            grp_len_r <= {AW{1'b0}};
            out_set_r <= {AW{1'b0}};
            out_len_r <= {AW{1'b0}};
            out_elem_r <= 2'h3;
            meas_init <= 1'b0;
            meas_abort <= 1'b0;
            func_defaults <= 1'b0;
            store_abort <= 1'b0;
            rd_data_r <= 32'h00000000;
            rd_err_r <= 1'b0;
        end else if (ce) begin
            meas_init <= 1'b0;
            meas_abort <= 1'b0;
            func_defaults <= 1'b0;
            store_abort <= 1'b0;
            // Plain register writes
            if (wr_stb) begin
                case (wr_addr)
                    `REG_CTRL: begin
                        talk_r <= wr_data[`CTRL_TALK_BIT];
                        elem_r <= wr_data[`CTRL_ELEM_LSB +: 3];
                    end
                    `REG_ARM_COUNT: arm_count_r <= arm_mrg[15:0];
                    `REG_TRIG_COUNT: trig_count_r <= trig_mrg[15:0];
                    `REG_TRIG_DELAY:
                        trig_delay_r <= merge(trig_delay_r, wr_data,
                                              wr_strb);
                    `REG_SETUP: setup_r <= wr_data[6:0];
                    `REG_STATUS: begin
                        if (wr_data[`ST_ERR_BIT])
                            cmd_err_r <= 1'b0;
                        if (wr_data[`ST_RESP_BIT])
                            resp_r <= 1'b0;
                    end
                    default: ;
                endcase
            end
            // Defer commands received while busy
            if (cmd_wr && !bad_func && !urgent && !take_new) begin
                if (pend_r && !take_pend)
                    cmd_err_r <= 1'b1;
                else begin
                    pend_r <= 1'b1;
                    pend_op_r <= cmd_op;
                    pend_func_r <= cmd_func;
                end
            end else if (take_pend) begin
                pend_r <= 1'b0;
            end
            if (bad_func)
                cmd_err_r <= 1'b1;
            // Store readings, end run when count met
            if (state_r == ST_RUN && rdg_valid) begin
                got_r <= got_r + 32'h1;
                if (got_r < (32'h1 << AW))
                    grp_len_r <= got_r[AW-1:0] + 1'b1;
            end
            if (run_done) begin
                state_r <= ST_IDLE;
                if (fetch_after_r) begin
                    fetch_after_r <= 1'b0;
                    out_set_r <= {AW{1'b0}};
                    out_len_r <= (got_r < (32'h1 << AW)) ?
                                 got_r[AW-1:0] + 1'b1 : grp_len_r;
                    out_elem_r <= next_elem(elem_r, 2'h0);
                end
            end
            // Execution of a taken command
            case (ex_op)
                `OP_CONF, `OP_MEAS: begin
                    if (ex_func != `FUNC_NONE)
                        func_sel_r <= ex_func;
                    func_defaults <= 1'b1;
                    setup_r[`SETUP_ARM_SRC_LSB +: 2] <= `SRC_IMMEDIATE;
                    setup_r[`SETUP_TRIG_SRC_LSB +: 2] <= `SRC_IMMEDIATE;
                    arm_count_r <= `RST_COUNT;
                    trig_count_r <= `RST_COUNT;
                    trig_delay_r <= `RST_DELAY;
                    setup_r[`SETUP_MATH_BIT] <= 1'b0;
                    setup_r[`SETUP_AZERO_BIT] <= 1'b1;
                    setup_r[`SETUP_BUF_BIT] <= 1'b0;
                    store_abort <= 1'b1;
                    // Event sources immediate above
                    // Stays idle unless measure goes on to read
                    if (ex_op == `OP_MEAS) begin
                        state_r <= ST_RUN;
                        meas_init <= 1'b1;
                        fetch_after_r <= 1'b1;
                        need_r <= 32'h1;
                        got_r <= 32'h0;
                    end
                end
                `OP_CONF_Q: begin
                    conf_resp_r <= func_sel_r;
                    resp_r <= 1'b1;
                end
                `OP_FETCH: begin
                    out_set_r <= {AW{1'b0}};
                    out_len_r <= grp_len_r;
                    out_elem_r <= next_elem(elem_r, 2'h0);
                end
                `OP_READ, `OP_INIT: begin
                    if (ex_op == `OP_READ && infinite)
                        cmd_err_r <= 1'b1;
                    else begin
                        state_r <= ST_RUN;
                        meas_init <= 1'b1;
                        fetch_after_r <= ex_op == `OP_READ;
                        need_r <= infinite ? 32'h0 : cnt_a * cnt_t;
                        got_r <= 32'h0;
                    end
                end
                default: ;
            endcase
            // Urgent commands act even while running
            if (cmd_wr && urgent) begin
                state_r <= ST_IDLE;
                meas_abort <= state_r == ST_RUN;
                fetch_after_r <= 1'b0;
                if (cmd_op == `OP_RESET) begin
                    pend_r <= 1'b0;
                    func_sel_r <= `RST_FUNC;
                    arm_count_r <= `RST_COUNT;
                    trig_count_r <= `RST_COUNT;
                    trig_delay_r <= `RST_DELAY;
                    setup_r <= `RST_SETUP;
                end
            end
            // Output queue pops only while addressed to talk
            if (pop) begin
                if (next_elem(elem_r, out_elem_r + 2'h1) != 2'h3)
                    out_elem_r <= next_elem(elem_r, out_elem_r + 2'h1);
                else if (out_set_r + 1'b1 == out_len_r) begin
                    out_len_r <= {AW{1'b0}};
                    out_elem_r <= 2'h3;
                end else begin
                    out_set_r <= out_set_r + 1'b1;
                    out_elem_r <= next_elem(elem_r, 2'h0);
                end
            end
            // Registered read data
            if (rd_stb) begin
                rd_err_r <= 1'b0;
                case (rd_addr)
                    `REG_CMD: rd_data_r <= 32'h00000000;
                    `REG_CTRL: rd_data_r <= {28'h0, elem_r, talk_r};
                    `REG_ARM_COUNT: rd_data_r <= {16'h0, arm_count_r};
                    `REG_TRIG_COUNT: rd_data_r <= {16'h0, trig_count_r};
                    `REG_TRIG_DELAY: rd_data_r <= trig_delay_r;
                    `REG_SETUP: rd_data_r <= {25'h0, setup_r};
                    `REG_STATUS: rd_data_r <= {21'h0, func_sel_r,
                        3'h0, resp_r, out_avail, cmd_err_r, pend_r,
                        idle_now};
                    `REG_OUT_DATA:
                        rd_data_r <= pop ? out_word : 32'h00000000;
                    `REG_CONF_RESP: rd_data_r <= {29'h0, conf_resp_r};
                    default: begin
                        rd_data_r <= 32'h00000000;
                        rd_err_r <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule // meas_seq

// *** meas_seq_assertions.sv ***
`timescale 1ns/1ps
// ****
// Port checker
// ****
module meas_seq_assertions (
    input wire sys_clk,
    input wire arst_n,
    input wire s_awready,
    input wire s_bvalid,
    input wire s_bready,
    input wire s_rvalid,
    input wire s_rready,
    input wire meas_init,
    input wire func_defaults,
    input wire store_abort,
    input wire [2:0] func_sel_r,
    input wire [15:0] arm_count_r,
    input wire [15:0] trig_count_r,
    input wire [31:0] trig_delay_r,
    input wire [6:0] setup_r
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    chk_init_pulse: assert property (meas_init |=> !meas_init)
        else $error("init pulse too long");
    chk_conf_counts: assert property (func_defaults |-> ##[0:1]
        (arm_count_r == 16'h0001 && trig_count_r == 16'h0001))
        else $error("counts not one");
    chk_conf_delay: assert property (func_defaults |-> ##[0:1]
        trig_delay_r == 32'h00000000) else $error("delay not zero");
    chk_conf_setup: assert property (func_defaults |-> ##[0:1]
        setup_r == 7'h02) else $error("setup not defaulted");
    chk_func_legal: assert property (func_sel_r >= 3'h1
        && func_sel_r <= 3'h4) else $error("illegal function");
    chk_bresp_hold: assert property (s_bvalid && !s_bready |=> s_bvalid)
        else $error("bvalid dropped");
    chk_rdata_hold: assert property (s_rvalid && !s_rready |=> s_rvalid)
        else $error("rvalid dropped");
    chk_aw_refused: assert property (s_bvalid |-> !s_awready)
        else $error("aw ready in response");
    chk_store_abort: assert property (func_defaults |-> store_abort)
        else $error("storage not aborted");
endmodule // meas_seq_assertions
bind meas_seq meas_seq_assertions u_chk (.sys_clk(sys_clk), .arst_n(arst_n),
    .s_awready(s_awready), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_rvalid(s_rvalid), .s_rready(s_rready), .meas_init(meas_init),
    .func_defaults(func_defaults), .func_sel_r(func_sel_r),
    .store_abort(store_abort),
    .arm_count_r(arm_count_r), .trig_count_r(trig_count_r),
    .trig_delay_r(trig_delay_r), .setup_r(setup_r));

// *** meas_engine.sv ***
`timescale 1ns/1ps
// ****
// Measurement engine model
// ****
module meas_engine #(parameter GAP = 20) (
    input wire sys_clk,
    input wire meas_init,
    input wire meas_abort,
    input wire [31:0] n_sets,
    output reg rdg_valid = 1'b0,
    output wire [31:0] rdg_value,
    output wire [31:0] rdg_time,
    output wire [31:0] rdg_status
);
    reg [31:0] seq_r = 32'h0;
    reg [31:0] num_r = 32'h0;
    reg [31:0] left_r = 32'h0;
    reg [31:0] cnt_r = 32'h0;
    // Idle lines show the inverse of the last set
    assign rdg_value = rdg_valid ? 32'hA0000000 + num_r : ~num_r;
    assign rdg_time = rdg_valid ? 32'hB0000000 + num_r : ~num_r;
    assign rdg_status = rdg_valid ? 32'hC0000000 + num_r : ~num_r;
    // One set per GAP+1 cycles until count or abort
    always @(posedge sys_clk) begin
        rdg_valid <= 1'b0;
        cnt_r <= cnt_r + 32'h1;
        if (meas_init) begin
            left_r <= n_sets;
            cnt_r <= 32'h0;
        end else if (meas_abort) begin
            left_r <= 32'h0;
        end else if (left_r != 32'h0 && cnt_r == GAP) begin
            rdg_valid <= 1'b1;
            num_r <= seq_r;
            seq_r <= seq_r + 32'h1;
            left_r <= left_r - 32'h1;
            cnt_r <= 32'h0;
        end
    end
endmodule // meas_engine

// *** tb_measurement_command_sequencer.sv ***
`timescale 1ns/1ps
`include "meas_seq_map.vh"
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin failures++; \
    $display("wrong value %s exp %h got %h", nm, e, s); end end
module tb_measurement_command_sequencer;
    reg sys_clk = 1'b0, arst_n = 1'b0, s_awvalid = 1'b0, s_wvalid = 1'b0;
    reg s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
    reg [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
    reg [31:0] s_wdata = 32'h0, rd_q, s0;
    wire s_awready, s_wready, s_bvalid, s_arready, s_rvalid, rdg_valid;
    wire meas_init, meas_abort;
    wire [1:0] s_bresp, s_rresp;
    wire [31:0] s_rdata, rdg_value, rdg_time, rdg_status, trig_delay_r;
    wire [2:0] func_sel_r;
    wire [15:0] arm_count_r, trig_count_r;
    wire [6:0] setup_r;
    integer failures = 0, n_compared = 0, i, j;
    meas_seq DUT (.sys_clk(sys_clk), .arst_n(arst_n), .ce(1'b1),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(4'hF), .s_wvalid(s_wvalid),
        .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
        .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
        .s_rvalid(s_rvalid), .s_rready(s_rready), .rdg_valid(rdg_valid),
        .rdg_value(rdg_value), .rdg_time(rdg_time), .rdg_status(rdg_status),
        .meas_init(meas_init), .meas_abort(meas_abort), .func_defaults(),
        .store_abort(), .func_sel_r(func_sel_r), .arm_count_r(arm_count_r),
        .trig_count_r(trig_count_r), .trig_delay_r(trig_delay_r),
        .setup_r(setup_r));
    meas_engine ENG (.sys_clk(sys_clk), .meas_init(meas_init),
        .meas_abort(meas_abort), .rdg_valid(rdg_valid),
        .n_sets({16'h0, arm_count_r} * {16'h0, trig_count_r}),
        .rdg_value(rdg_value), .rdg_time(rdg_time), .rdg_status(rdg_status));
    // Clock and watchdog
    initial forever #2.5 sys_clk = ~sys_clk;
    initial begin
        #200000;
        failures++;
        end_of_test;
    end
    // AXI4-Lite write (w=1) or read (w=0)
    task acc(input w, input [7:0] a, input [31:0] d);
        @(posedge sys_clk);
        s_awaddr <= a;
        s_araddr <= a;
        s_wdata <= d;
        s_awvalid <= w;
        s_wvalid <= w;
        s_bready <= w;
        s_arvalid <= !w;
        s_rready <= !w;
        do begin
            @(posedge sys_clk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
            if (s_arready) s_arvalid <= 1'b0;
        end while (!(w ? s_bvalid : s_rvalid));
        s_bready <= 1'b0;
        s_rready <= 1'b0;
        rd_q = s_rdata;
    endtask
    task cmd(input [31:0] d);
        acc(1'b1, `REG_CMD, d);
    endtask
    task rchk(input [7:0] a, input [31:0] e);
        acc(1'b0, a, 32'h0);
        `CHK("rdata", e, rd_q)
    endtask
    task wait_idle;
        do acc(1'b0, `REG_STATUS, 32'h0);
        while (rd_q[`ST_IDLE_BIT] !== 1'b1);
    endtask
    function [31:0] word(input integer k);
        word = 32'hA0000000 + (k % 3) * 32'h10000000 + s0 + k / 3;
    endfunction
    task end_of_test;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Tests; counts stay finite
    initial begin
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        rchk(`REG_CTRL, 32'h0000000E);
        acc(1'b1, `REG_TRIG_COUNT, 32'h2);
        acc(1'b1, `REG_CTRL, 32'h0000000F);
        s0 = ENG.seq_r;
        cmd(32'h4);
        wait_idle;
        for (j = 0; j < 2; j++) begin
            if (j == 1) cmd(32'h3);
            for (i = 0; i < 6; i++) rchk(`REG_OUT_DATA, word(i));
        end
        rchk(`REG_TRIG_COUNT, 32'h2);
        acc(1'b1, `REG_CTRL, 32'h0000000E);
        cmd(32'h3);
        rchk(`REG_OUT_DATA, 32'h0);
        acc(1'b1, `REG_CTRL, 32'h00000003);
        cmd(32'h3);
        rchk(`REG_OUT_DATA, word(0));
        rchk(`REG_OUT_DATA, word(3));
        for (i = 1; i < 5; i++) begin
            acc(1'b1, `REG_SETUP, 32'h79);
            acc(1'b1, `REG_TRIG_DELAY, 32'h7);
            cmd(32'h1 | (i << 4));
            `CHK("function", i[2:0], func_sel_r)
            `CHK("setup", 7'h02, setup_r)
            cmd(32'h2);
            rchk(`REG_CONF_RESP, i);
        end
        cmd(32'h71);
        acc(1'b0, `REG_STATUS, 32'h0);
        `CHK("error", 1'b1, rd_q[`ST_ERR_BIT])
        acc(1'b1, `REG_TRIG_COUNT, 32'h2);
        cmd(32'h4);
        cmd(32'h31);
        acc(1'b0, `REG_STATUS, 32'h0);
        `CHK("pending", 1'b1, rd_q[`ST_PEND_BIT])
        `CHK("function", 3'h4, func_sel_r)
        wait_idle;
        `CHK("function", 3'h3, func_sel_r)
        cmd(32'h4);
        cmd(32'h21);
        cmd(32'h8);
        wait_idle;
        `CHK("function", 3'h1, func_sel_r)
        acc(1'b1, `REG_TRIG_COUNT, 32'h2);
        acc(1'b1, `REG_CTRL, 32'h00000003);
        s0 = ENG.seq_r;
        cmd(32'h5);
        wait_idle;
        `CHK("function", 3'h1, func_sel_r)
        rchk(`REG_OUT_DATA, word(0));
        rchk(`REG_OUT_DATA, 32'h0);
        end_of_test;
    end
endmodule // tb_measurement_command_sequencer
